/* File: boot_loader_pkg.sv */
// constants and carrier types shared by the serial rom boot loader
// assumes a 50 MHz core clock and a serial rom with read-command framing
package boot_loader_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_MHZ    = 50;
  localparam int POR_HOLD_NS     = 1000;   // stretch after the reset pin releases
  localparam int POR_HOLD_CYCLES = (POR_HOLD_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int ROM_HALF_DIV    = 4;      // link cycles per half serial clock

  // ****************************************
  // rom framing
  // ****************************************
  localparam int          ROM_ADDR_W  = 8;
  localparam int          ROM_DATA_W  = 16;
  localparam int          ROM_WORDS   = 16;
  localparam logic [2:0]  READ_PREFIX = 3'h6;  // start bit then read opcode
  localparam int          CMD_BITS    = 3 + ROM_ADDR_W;
  localparam int          SEL_GAP_MIN = ROM_HALF_DIV;

  // one loaded word with its rom address
  typedef struct packed {
    logic [ROM_ADDR_W-1:0] index;
    logic [ROM_DATA_W-1:0] data;
  } romWord_type;

endpackage

/* File: rom_model.sv */
// serial rom model answering read commands on the resolved link pins
// assumes the bench resolves the pulls and feeds the data line level back
`timescale 1ns/1ns
`default_nettype none

module rom_model
  import boot_loader_pkg::*;
(
  input  wire logic                            romClk,
  input  wire logic                            romSel,
  input  wire logic                            romDin,
  input  wire logic [ROM_WORDS*ROM_DATA_W-1:0] memFlat,
  output logic                                 romDout,
  output logic                                 romDoutEn
);
  // ********************
  // command and answer
  // ********************
  logic [10:0]           cmd = 11'h0;
  logic [3:0]            bitCount = 4'h0;
  logic [4:0]            sentCount = 5'h0;
  logic                  cmdOk = 1'b0;
  logic                  drvOn = 1'b0;
  logic [ROM_DATA_W-1:0] word = 16'h0;
  wire  [10:0]           nextCmd = {cmd[9:0], romDin};

  // shift command bits mid-period; deselect restarts the framing
  always @(negedge romClk or negedge romSel)
    if (!romSel)
      bitCount <= 4'h0;
    else if (bitCount < 4'hB)
    begin
      cmd      <= nextCmd;
      bitCount <= bitCount + 4'h1;
      cmdOk    <= (nextCmd[10:8] == READ_PREFIX);
      word     <= memFlat[nextCmd[3:0]*ROM_DATA_W +: ROM_DATA_W];
    end

  // one data bit per rising edge, msb first, once a read is framed
  always @(posedge romClk)
    if (bitCount == 4'hB && cmdOk && sentCount < 5'h10)
    begin
      drvOn     <= 1'b1;
      romDout   <= word[4'hF - sentCount[3:0]];
      sentCount <= sentCount + 5'h1;
    end
    else
    begin
      drvOn <= 1'b0;
      if (bitCount != 4'hB)
        sentCount <= 5'h0;
    end

  // released when deselected, so the pull-up decides the line, never a stale bit
  assign romDoutEn = drvOn & romSel;
endmodule // rom_model

`default_nettype wire

/* File: serial_eeprom_boot_loader.sv */
// reset stretcher plus automatic serial rom loader
// assumes sys_rst is the power-on source and linkClk is free running
//
// Overview of operation
// [R1] serial clock driven only during access
// [R2] select high, changes on clock rising edge
// [R3] data out changes on rising edge only
// [R4] reset pin active low feeds chip reset
// [R5] load starts by itself after reset ends
// [R6] select held per word, dropped between words
`timescale 1ns/1ns
`default_nettype none

module serial_eeprom_boot_loader
  import boot_loader_pkg::*;
#(
  parameter int WORD_COUNT  = ROM_WORDS,
  parameter int HALF_DIV    = ROM_HALF_DIV,
  parameter int HOLD_CYCLES = POR_HOLD_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEn,
  input  wire logic                  linkClk,
  input  wire logic                  extResetN,
  output logic                       chipResetOut,
  output logic                       loadDone,
  output logic                       cfgValid,
  output boot_loader_pkg::romWord_type cfgWord,
  output logic                       romSerialClockOut,
  output logic                       romSerialClockOutEn,
  output logic                       romSelectOut,
  output logic                       romSelectOutEn,
  output logic                       romSerialDataLineOut,
  output logic                       romSerialDataLineOutEn,
  input  wire logic                  romSerialDataLineIn
);
  import boot_loader_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;

  typedef enum logic [1:0] {LINK_IDLE, LINK_GAP, LINK_CMD, LINK_READ} link_type;

  // ****************************************
  // core domain: reset stretch and word intake
  // ****************************************
  logic          extSync;
  logic          reqSeen;
  logic          doneSeen;
  logic [HW-1:0] holdCnt;
  logic          startToggle;
  logic          ackToggle;
  logic          reqPrev;
  logic          reqToggle;
  logic          loadDoneLink;
  romWord_type   wordHold;
  logic          loadStale;

  // pin reset syncs to asserted so the chip stays held until it is seen high
  sync_two_flop #(.W(3), .RST_VAL(32'h0)) coreSync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({extResetN, reqToggle, loadDoneLink}),
    .q   ({extSync, reqSeen, doneSeen})
  );

  wire          extLow        = ~extSync;
  wire          reqEdge       = reqSeen ^ reqPrev;
  wire [HW-1:0] next_holdCnt  = extLow ? HW'(HOLD_CYCLES)
                              : (holdCnt != '0) ? holdCnt - HW'(1) : holdCnt;
  wire          resetEnding   = chipResetOut & (next_holdCnt == '0);

  // reset output follows the stretch counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      holdCnt      <= HW'(HOLD_CYCLES);
      chipResetOut <= 1'b1;
      startToggle  <= 1'b0;
    end
    else if (clkEn)
    begin
      holdCnt      <= next_holdCnt;
      chipResetOut <= (next_holdCnt != '0);            // [R4]
      startToggle  <= startToggle ^ resetEnding;        // [R5]
    end
  end

  // word arrives by toggle; held data is stable until the ack toggles back
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reqPrev   <= 1'b0;
      ackToggle <= 1'b0;
      cfgValid  <= 1'b0;
      cfgWord   <= '0;
      loadDone  <= 1'b0;
      loadStale <= 1'b0;
    end
    else if (clkEn)
    begin
      reqPrev   <= reqSeen;
      ackToggle <= reqSeen;
      cfgValid  <= reqEdge;
      if (reqEdge)
        cfgWord <= wordHold;
      // done level from the last load lags the new start, so mask it until it drops
      loadStale <= resetEnding | (loadStale & doneSeen);   // set wins over clear
      loadDone  <= doneSeen & ~chipResetOut & ~loadStale;  // [R5]
    end
  end

  // ****************************************
  // link domain: serial rom engine
  // ****************************************
  logic                linkRstMeta;
  logic                linkRst;
  logic                linkEn;
  logic                startSeen;
  logic                ackSeen;
  logic                dataIn;
  logic                startPrev;
  link_type            state;
  logic [DW-1:0]       halfCnt;
  logic [4:0]          bitCnt;
  logic [ROM_ADDR_W:0] wordIdx;
  logic [CMD_BITS-1:0] cmdShift;
  logic [ROM_DATA_W-1:0] rdShift;

  // reset asserts at once and releases on a link edge
  always_ff @(posedge linkClk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      linkRstMeta <= 1'b1;
      linkRst     <= 1'b1;
    end
    else
    begin
      linkRstMeta <= 1'b0;
      linkRst     <= linkRstMeta;
    end
  end

  // enable crosses too, so one low level freezes both domains
  sync_two_flop #(.W(4), .RST_VAL(32'h0)) linkSync (
    .clk (linkClk),
    .rst (linkRst),
    .d   ({clkEn, startToggle, ackToggle, romSerialDataLineIn}),
    .q   ({linkEn, startSeen, ackSeen, dataIn})
  );

  wire                active   = (state != LINK_IDLE);
  wire                tick     = active & (halfCnt == DW'(HALF_DIV - 1));
  wire                rising   = tick & ~romSerialClockOut;
  wire                falling  = tick & romSerialClockOut;
  wire                startEdge = startSeen ^ startPrev;
  wire                ackClear = (ackSeen == reqToggle);
  wire [CMD_BITS-1:0] cmdWord  = {READ_PREFIX, wordIdx[ROM_ADDR_W-1:0]};
  wire                lastWord = (wordIdx == (ROM_ADDR_W + 1)'(WORD_COUNT));

  // pins drive only while a load runs, the pulls hold them otherwise
  assign romSerialClockOutEn = active;  // [R1]
  assign romSelectOutEn      = active;  // [R2]

  // half-period divider; the rom clock is made here, not a third domain
  always_ff @(posedge linkClk or posedge linkRst)
  begin
    if (linkRst)
    begin
      halfCnt   <= '0;
      startPrev <= 1'b0;
    end
    else if (linkEn)
    begin
      halfCnt   <= (!active || tick) ? '0 : halfCnt + DW'(1);
      startPrev <= startSeen;
    end
  end

  // serial engine: select, clock and data move together on rising edges
  always_ff @(posedge linkClk or posedge linkRst)
  begin
    if (linkRst)
    begin
      state                  <= LINK_IDLE;
      romSerialClockOut      <= 1'b0;
      romSelectOut           <= 1'b0;
      romSerialDataLineOut   <= 1'b0;
      romSerialDataLineOutEn <= 1'b0;
      bitCnt                 <= '0;
      wordIdx                <= '0;
      cmdShift               <= '0;
      rdShift                <= '0;
      wordHold               <= '0;
      reqToggle              <= 1'b0;
      loadDoneLink           <= 1'b0;
    end
    else if (linkEn)
    begin
      unique case (state)
        LINK_IDLE:
          if (startEdge)
          begin
            state        <= LINK_GAP;                   // [R5]
            wordIdx      <= '0;
            loadDoneLink <= 1'b0;
          end
        LINK_GAP:
          if (falling)
            romSerialClockOut <= 1'b0;
          else if (tick && ackClear && lastWord)
          begin
            state        <= LINK_IDLE;
            loadDoneLink <= 1'b1;
          end
          else if (tick && ackClear)
          begin
            state                  <= LINK_CMD;
            romSerialClockOut      <= 1'b1;
            romSelectOut           <= 1'b1;             // [R2] [R6]
            romSerialDataLineOutEn <= 1'b1;
            romSerialDataLineOut   <= cmdWord[CMD_BITS-1];
            cmdShift               <= cmdWord << 1;
            bitCnt                 <= '0;
          end
        LINK_CMD:
        begin
          if (tick)
            romSerialClockOut <= ~romSerialClockOut;
          if (rising && bitCnt == 5'(CMD_BITS - 1))
          begin
            state                  <= LINK_READ;
            romSerialDataLineOutEn <= 1'b0;             // [R3]
            bitCnt                 <= '0;
          end
          else if (rising)
          begin
            romSerialDataLineOut <= cmdShift[CMD_BITS-1]; // [R3]
            cmdShift             <= cmdShift << 1;
            bitCnt               <= bitCnt + 5'(1);
          end
        end
        LINK_READ:
        begin
          if (tick)
            romSerialClockOut <= ~romSerialClockOut;
          if (falling)
          begin
            rdShift <= {rdShift[ROM_DATA_W-2:0], dataIn};
            bitCnt  <= bitCnt + 5'(1);
          end
          if (rising && bitCnt == 5'(ROM_DATA_W))
          begin
            state          <= LINK_GAP;
            romSelectOut   <= 1'b0;                     // [R6]
            wordHold.index <= wordIdx[ROM_ADDR_W-1:0];
            wordHold.data  <= rdShift;
            reqToggle      <= ~reqToggle;
            wordIdx        <= wordIdx + (ROM_ADDR_W + 1)'(1);
          end
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence selLowGap;
    !romSelectOut [*4];
  endsequence

  sequence wordFrame;
    $rose(romSelectOut) ##1 romSelectOut [*8];
  endsequence

  AST_CLOCK_RELEASED: // [R1]
    assert property (@(posedge linkClk) disable iff (linkRst)
      !active |-> !romSerialClockOutEn && !romSelectOutEn && !romSerialDataLineOutEn
                  && !romSerialClockOut && !romSelectOut)
    else $error("rom pins driven outside an access");

  AST_SELECT_ON_RISE: // [R2]
    assert property (@(posedge linkClk) disable iff (linkRst)
      $changed(romSelectOut) && active |-> $rose(romSerialClockOut))
    else $error("select moved without a clock rising edge");

  AST_DATA_ON_RISE: // [R3]
    assert property (@(posedge linkClk) disable iff (linkRst)
      $changed(romSerialDataLineOut) && $past(romSerialDataLineOutEn) |-> $rose(romSerialClockOut))
    else $error("data moved without a clock rising edge");

  AST_DATA_ONLY_CMD: // [R3]
    assert property (@(posedge linkClk) disable iff (linkRst)
      romSerialDataLineOutEn |-> state == LINK_CMD && romSelectOut)
    else $error("data line driven outside a command");

  AST_PIN_HOLDS_RESET: // [R4]
    assert property (@(posedge clk) disable iff (sys_rst)
      extLow && clkEn |=> chipResetOut ##1 chipResetOut)
    else $error("reset released while pin still low");

  AST_LOAD_AUTO: // [R5]
    assert property (@(posedge clk) disable iff (sys_rst)
      $fell(chipResetOut) |-> startToggle != $past(startToggle))
    else $error("load not started at end of reset");

  AST_SELECT_GAP: // [R6]
    assert property (@(posedge linkClk) disable iff (linkRst)
      $fell(romSelectOut) |-> selLowGap)
    else $error("select gap between words too short");

  AST_WORD_FRAME: // [R6]
    assert property (@(posedge linkClk) disable iff (linkRst)
      $rose(romSelectOut) |-> wordFrame)
    else $error("select dropped early in a word");

  AST_SELECT_HELD: // [R6]
    assert property (@(posedge linkClk) disable iff (linkRst)
      (state == LINK_CMD || state == LINK_READ) |-> romSelectOut)
    else $error("select dropped inside a word");

  AST_FRAME_THEN_GAP: // [R6]
    assert property (@(posedge linkClk) disable iff (linkRst)
      $fell(romSelectOut) |-> state == LINK_GAP ##0 $past(state) == LINK_READ)
    else $error("select fell outside the end of a read");

endmodule // serial_eeprom_boot_loader

`default_nettype wire

/* File: sync_two_flop.sv */
// two-flop synchroniser for a group of unrelated levels
// assumes each bit is a level that stays put for several destination cycles
`timescale 1ns/1ns
`default_nettype none

module sync_two_flop #(
  parameter int          W       = 1,
  parameter logic [31:0] RST_VAL = 32'h0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= RST_VAL[W-1:0];
      q    <= RST_VAL[W-1:0];
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // sync_two_flop

`default_nettype wire

/* File: test_serial_eeprom_boot_loader.sv */
// self-checking bench: boot loader against the serial rom model
// assumes the loader package and rom_model are compiled first
`timescale 1ns/1ns
`default_nettype none

module test_serial_eeprom_boot_loader;
  import boot_loader_pkg::*;
  localparam int NW   = 2;
  localparam int HOLD = 4;

  logic                            clk = 1'b0;
  logic                            linkClk = 1'b0;
  logic                            sys_rst = 1'b1;
  logic                            extResetN = 1'b1;
  logic                            clkEn = 1'b1;
  logic                            chipResetOut, loadDone, cfgValid;
  romWord_type                     cfgWord;
  logic                            sclk, sclkEn, sel, selEn, dOut, dOutEn, dRom, dRomEn;
  logic [ROM_WORDS*ROM_DATA_W-1:0] memFlat = '0;
  logic [31:0]                     lfsr = 32'h945C5929;
  logic                            pClk = 1'b0, pSel = 1'b0, pD = 1'b0, pDEn = 1'b0;
  int                              fail_count = 0, checks_done = 0, cycles = 0, gap = 0, rises = 0;
  romWord_type                     expQ[$];
  wire                             clkPin  = sclkEn & sclk;   // pull-down when released
  wire                             selPin  = selEn & sel;     // pull-down when released
  wire                             dataPin = dOutEn ? dOut : (dRomEn ? dRom : 1'b1);

  // ********************
  // clocks and instances
  // ********************
  always #10 clk = ~clk;
  initial
  begin
    #1;
    forever #3 linkClk = ~linkClk;
  end

  serial_eeprom_boot_loader #(.WORD_COUNT(NW), .HALF_DIV(ROM_HALF_DIV), .HOLD_CYCLES(HOLD)) dut (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk), .extResetN(extResetN),
    .chipResetOut(chipResetOut), .loadDone(loadDone), .cfgValid(cfgValid), .cfgWord(cfgWord),
    .romSerialClockOut(sclk), .romSerialClockOutEn(sclkEn), .romSelectOut(sel), .romSelectOutEn(selEn),
    .romSerialDataLineOut(dOut), .romSerialDataLineOutEn(dOutEn), .romSerialDataLineIn(dataPin));
  rom_model rom (.romClk(clkPin), .romSel(selPin), .romDin(dataPin), .memFlat(memFlat), .romDout(dRom),
    .romDoutEn(dRomEn));

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("counts: checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // fresh random contents, then note the words a load must deliver in order
  task automatic fillRom;
    for (int i = 0; i < ROM_WORDS; i++)
    begin
      lfsr = nextRand(lfsr);
      memFlat[i*ROM_DATA_W +: ROM_DATA_W] = lfsr[15:0];
    end
    for (int i = 0; i < NW; i++)
      expQ.push_back({i[7:0], memFlat[i*ROM_DATA_W +: ROM_DATA_W]});
  endtask

  task automatic waitDone;
    int n = 0;
    while ((expQ.size() != 0 || loadDone !== 1'b1) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    #2;
    check(expQ.size(), 0);
    check(loadDone, 1'b1);
    check({sclkEn, selEn, dOutEn, clkPin, selPin, dataPin}, 6'h01);
  endtask

  // hang guard well beyond three short loads
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      final_report();
    end
  end

  // scoreboard: oldest noted word against each delivered word
  // a frozen edge repeats the last pulse, so only enabled edges count
  always @(posedge clk)
  begin
    #1;
    if (cfgValid === 1'b1 && clkEn === 1'b1)
    begin
      if (expQ.size() == 0)
        check(cfgWord, 32'hFFFFFFFF);
      else
        check(cfgWord, expQ.pop_front());
    end
  end

  // pin watcher mid link period, after registered pin changes have landed
  always @(negedge linkClk)
  begin
    if (selEn === 1'b1 && selPin !== pSel) check({pClk, clkPin}, 2'h1);
    if (dOutEn === 1'b1 && pDEn && dOut !== pD) check({pClk, clkPin}, 2'h1);
    if (sclkEn === 1'b1) check(chipResetOut, 1'b0);
    if (selEn === 1'b1 && pSel && !selPin) check(rises, 27);
    if (selEn === 1'b1 && !pSel && selPin) check(gap >= ROM_HALF_DIV, 1'b1);
    gap   = (selEn === 1'b1 && !selPin) ? gap + 1 : 0;
    rises = !selPin ? 0 : rises + ((clkPin && !pClk) ? 1 : 0);
    pClk  = clkPin;
    pSel  = selPin;
    pD    = dOut;
    pDEn  = (dOutEn === 1'b1);
  end

  // ********************
  // main sequence
  // ********************
  initial
  begin
    int n;
    fillRom();
    repeat (6) @(posedge clk);
    check({sclkEn, selEn, dOutEn, chipResetOut, loadDone}, 5'h02);
    #2 sys_rst = 1'b0;
    check(chipResetOut, 1'b1);
    repeat (30) @(posedge clk);
    #2 clkEn = 1'b0;
    lfsr = nextRand(lfsr);
    repeat (3 + lfsr[2:0]) @(posedge clk);
    #2 clkEn = 1'b1;
    waitDone();
    $display("test 1 done: load after power-on");
    fillRom();
    @(posedge clk) #2 extResetN = 1'b0;
    repeat (3) @(posedge clk);
    #2 check(chipResetOut, 1'b1);
    repeat (3) @(posedge clk);
    #2 extResetN = 1'b1;
    n = 0;
    while (chipResetOut === 1'b1 && n < 100)
    begin
      @(posedge clk) #2;
      n++;
    end
    check(n, HOLD + 2); // two sync edges, then the stretch
    @(posedge clk) #2 check(loadDone, 1'b0); // no stale done ahead of the reload
    waitDone();
    $display("test 2 done: reload after reset pin pulse");
    fillRom();
    @(posedge clk) #2 sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    #2 sys_rst = 1'b0;
    n = 0;
    while (selEn !== 1'b1 && n < 300)
    begin
      @(posedge clk) #2;
      n++;
    end
    check(selEn, 1'b1);
    repeat (20) @(posedge clk);
    #2 sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    check({sclkEn, selEn, dOutEn, selPin, chipResetOut}, 5'h01);
    #2 sys_rst = 1'b0;
    waitDone();
    $display("test 3 done: reset in mid command");
    final_report();
  end
endmodule // test_serial_eeprom_boot_loader

`default_nettype wire
